/* core/rxss_sync_status.sv */
// Purpose: Receive synchronisation machine and per-character status encoder
// Assumes: Decoder flags arrive on ref_clk with a one-cycle charValid strobe
// Notes:   bondInhibit and pllLock are pins and pass two flip-flops first
`timescale 1ns/1ps

// Functional notes
// R1: Valid special character reports status 001
// R2: Bonded channels locked: 010 on last cycle
// R3: Framing pattern match reports 011, data kept
// R4: Undecodable character: 100 and C0.7 substituted
// R5: Lost sync or buffer error reports 101
// R6: Disparity error: 110 and substitute character
// R7: Realign state reports 111 with decoded value
// R8: Self-test last character bad reports 100
// R9: Self-test compare mismatch reports 110
// R10: Self-test not started, PLL, buffer: 101
// R11: Four states; only realign and synced emit several codes
// R12: Type A bond timeout: inhibit low, window expired
// R13: One framing, four framing: separate transitions
// R14: Realign exit on buffer, PLL, decoder error
// R15: Sync drop: buffer, PLL, four errors, balance
// R16: Type A enters data on valid non-framing
// R17: Type B timeout: window and inhibit/master fail
// R18: Type B realign exit adds bond timeout
// R19: Type B data entry needs master bond
// R20: Type B bond-failed exits: buffer/PLL, decoder error
// R21: Lowest priority rank wins on conflict
// R22: Machine runs only with bonding mode set
// R23: Mode bit 0 selects Type A or B
// R24: Unbonded modes other than self-test never report 111 or 010
module rxss_sync_status
  import rxss_pkg::*;
(
  input  wire logic        ref_clk,        // 100 MHz clock
  input  wire logic        rst,            // Async reset, active high
  input  wire logic [3:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [3:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  input  wire logic        charValid,      // Decoded character strobe
  input  wire logic [7:0]  decodedChar,    // Decoded character value
  input  wire logic        charFraming,    // Matches framing_pattern_select
  input  wire logic        charSpecial,    // Valid special character
  input  wire logic        charCodeErr,    // Undecodable character
  input  wire logic        charDispErr,    // Running disparity error
  input  wire logic        ebufErr,        // Elasticity buffer under/overrun
  input  wire logic        pllLock,        // Receive PLL lock pin
  input  wire logic        bond_inhibit,   // Bond inhibit pin
  input  wire logic        deskewExpired,  // Deskew window expired
  input  wire logic        masterBondFail, // Master channel did not bond
  input  wire logic        bondedToMaster, // Channel bonded to master
  input  wire logic        stStarted,      // Self-test compares begun
  input  wire logic        stLastBad,      // Self-test last char invalid
  input  wire logic        stLastGood,     // Self-test last char good
  input  wire logic        stMismatch,     // Self-test compare mismatch
  output logic [7:0]       rxChar,         // Output character
  output logic [2:0]       rx_char_status, // Character status code
  output logic             rxCharValid     // Output character strobe
);
  import rxss_pkg::*;

  logic [2:0]  rx_mode_select;
  logic [31:0] charCount;
  logic        inhMeta, inhSync, lockMeta, lockSync;
  rxss_state_e state, next_state;
  logic [2:0]  framingCnt, errCnt, balance;
  logic        decErr, lockLost, fourFraming, fourErr, balanceHit, bondTimeout;
  logic        bonded, typeB, selfTest, syncDrop, realignExit, enterLock;
  logic [2:0]  next_status;
  logic [7:0]  next_char;
  logic        awTaken, wTaken;
  logic [3:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inhMeta  <= 1'b0;
      inhSync  <= 1'b0;
      lockMeta <= 1'b0;
      lockSync <= 1'b0;
    end else begin
      inhMeta  <= bond_inhibit;
      inhSync  <= inhMeta;
      lockMeta <= pllLock;
      lockSync <= lockMeta;
    end
  end

  // Mode decode and condition terms
  assign typeB       = rx_mode_select[CTRL_TYPEB];                      // R23
  assign bonded      = rx_mode_select[CTRL_BOND];                       // R22
  assign selfTest    = rx_mode_select[CTRL_SELFT];
  assign decErr      = charCodeErr | charDispErr;
  assign lockLost    = ~lockSync;
  assign fourFraming = charFraming && (framingCnt == CNT_THREE);        // R13
  assign fourErr     = decErr && (errCnt == CNT_THREE);
  assign balanceHit  = decErr && (balance == CNT_THREE);
  assign bondTimeout = deskewExpired & (~inhSync | (typeB & masterBondFail)); // R12 R17
  assign syncDrop    = ebufErr | lockLost | fourErr | balanceHit;       // R15
  assign realignExit = ebufErr | lockLost | decErr | (typeB & bondTimeout); // R14 R18

  // Consecutive framing, consecutive error and invalid-minus-valid counters
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      framingCnt <= CNT_ZERO;
      errCnt     <= CNT_ZERO;
      balance    <= CNT_ZERO;
    end else if (charValid) begin
      framingCnt <= charFraming ? ((framingCnt == CNT_FOUR) ? CNT_FOUR : framingCnt + 3'h1)
                                : CNT_ZERO;
      errCnt     <= decErr ? ((errCnt == CNT_FOUR) ? CNT_FOUR : errCnt + 3'h1) : CNT_ZERO;
      if (decErr && balance != CNT_FOUR)
        balance <= balance + 3'h1;
      else if (!decErr && balance != CNT_ZERO)
        balance <= balance - 3'h1;
      if (state == SY_UNSYNC)
        balance <= CNT_ZERO;
    end
  end

  // Next-state logic for the synchronisation machine
  always_comb begin
    next_state = state;
    enterLock  = 1'b0;
    if (!bonded) begin
      next_state = SY_UNSYNC;                                           // R22
    end else if (ebufErr || lockLost) begin
      next_state = SY_UNSYNC;                                           // R20
    end else if (charValid) begin
      case (state)
        SY_UNSYNC: begin
          if (charFraming)
            next_state = SY_REALIGN;                                    // R13
        end
        SY_REALIGN: begin
          if (realignExit) begin
            next_state = SY_UNSYNC;
          end else if (!typeB && fourFraming) begin
            next_state = SY_SYNCED;                                     // R13
            enterLock  = 1'b1;
          end else if (typeB && charFraming && bondedToMaster && !deskewExpired) begin
            next_state = SY_SYNCED;                                     // R19
            enterLock  = 1'b1;
          end else if (!typeB && bondTimeout) begin
            next_state = SY_BONDFAIL;                                   // R12
          end
        end
        SY_SYNCED: begin
          if (syncDrop)
            next_state = SY_UNSYNC;                                     // R15
          else if (typeB && bondTimeout && !bondedToMaster)
            next_state = SY_BONDFAIL;                                   // R17
        end
        SY_BONDFAIL: begin
          if (typeB && decErr)
            next_state = SY_REALIGN;                                    // R20
          else if (!typeB && syncDrop)
            next_state = SY_UNSYNC;
          else if (!typeB && !decErr && !charFraming)
            next_state = SY_SYNCED;                                     // R16
        end
        default: next_state = SY_UNSYNC;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      state <= SY_UNSYNC;
    else
      state <= next_state;
  end

  // Status encoder: checks run from rank 1 downward so the lowest rank wins
  always_comb begin
    next_char   = decodedChar;
    next_status = ST_DATA;
    if (charCodeErr)
      next_char = CHAR_C0_7;                                            // R4
    else if (charDispErr && !charFraming)
      next_char = CHAR_C4_7;                                            // R3 R6
    if (selfTest) begin
      if (!stStarted || lockLost || ebufErr)
        next_status = ST_LOSS;                                          // R10
      else if (stLastGood)
        next_status = ST_LOCK;
      else if (stLastBad)
        next_status = ST_VIOL;                                          // R8
      else if (stMismatch)
        next_status = ST_DISPERR;                                       // R9
    end else if (bonded && (state == SY_UNSYNC || state == SY_BONDFAIL ||
                 (state == SY_SYNCED && syncDrop) || ebufErr || lockLost)) begin
      next_status = ST_LOSS;                                            // R5 R11 R21
    end else if (!bonded && (ebufErr || lockLost)) begin
      next_status = ST_LOSS;                                            // R5
    end else if (bonded && enterLock) begin
      next_status = ST_LOCK;                                            // R2 R24
    end else if (bonded && state == SY_REALIGN) begin
      next_status = ST_REALIGN;                                         // R7 R11 R24
    end else if (charCodeErr) begin
      next_status = ST_VIOL;                                            // R4
    end else if (charFraming) begin
      next_status = ST_FRAMING;                                         // R3
    end else if (charDispErr) begin
      next_status = ST_DISPERR;                                         // R6
    end else if (charSpecial) begin
      next_status = ST_SPECIAL;                                         // R1
    end
  end

  // Output register for character, status and strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxChar         <= 8'h00;
      rx_char_status <= ST_DATA;
      rxCharValid    <= 1'b0;
    end else begin
      rxCharValid <= charValid;
      if (charValid) begin
        rxChar         <= next_char;
        rx_char_status <= next_status;
      end
    end
  end

  // Character counter shown to software
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      charCount <= 32'h0000_0000;
    else if (charValid)
      charCount <= charCount + 32'h0000_0001;
  end

  // AXI write channel: address and data taken in either order
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awTaken       <= 1'b0;
      wTaken        <= 1'b0;
      awAddr        <= 4'h0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken       <= 1'b1;
        awAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken       <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (awTaken && wTaken && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        awTaken       <= 1'b0;
        wTaken        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control register write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      rx_mode_select <= CTRL_RESET;
    else if (awTaken && wTaken && !s_axi_bvalid && awAddr == REG_CTRL && wStrb[0])
      rx_mode_select <= wData[2:0];
  end

  // AXI read channel with address decode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
        s_axi_rdata <= {29'h0, rx_mode_select};
      end else if (s_axi_araddr == REG_STATUS) begin
        s_axi_rdata <= {20'h0, lockSync, inhSync, balance, rx_char_status,
                        2'(state), 2'h0};
      end else if (s_axi_araddr == REG_CHARCNT) begin
        s_axi_rdata <= charCount;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks on status encoding and machine transitions
  chk_viol_subst: assert property (@(posedge ref_clk) disable iff (rst) // R4
    charValid && charCodeErr && !selfTest && !bonded && !ebufErr && !lockLost
    |=> rx_char_status == ST_VIOL && rxChar == CHAR_C0_7)
    else $error("codeword violation not reported");
  chk_disp_subst: assert property (@(posedge ref_clk) disable iff (rst) // R6
    charValid && charDispErr && !charCodeErr && !charFraming && !selfTest && !bonded
    && !ebufErr && !lockLost |=> rx_char_status == ST_DISPERR && rxChar == CHAR_C4_7)
    else $error("disparity error not reported");
  chk_special_code: assert property (@(posedge ref_clk) disable iff (rst) // R1
    charValid && charSpecial && !decErr && !charFraming && !selfTest && !bonded
    && !ebufErr && !lockLost |=> rx_char_status == ST_SPECIAL)
    else $error("special code not reported");
  chk_framing_keep: assert property (@(posedge ref_clk) disable iff (rst) // R3
    charValid && charFraming && !decErr && !selfTest && !bonded && !ebufErr && !lockLost
    |=> rx_char_status == ST_FRAMING && rxChar == $past(decodedChar))
    else $error("framing match not reported");
  chk_buffer_loss: assert property (@(posedge ref_clk) disable iff (rst) // R5
    charValid && ebufErr && !selfTest |=> rx_char_status == ST_LOSS)
    else $error("loss of sync not reported");
  chk_realign_code: assert property (@(posedge ref_clk) disable iff (rst) // R7
    charValid && bonded && !selfTest && state == SY_REALIGN && next_state == SY_REALIGN
    && !ebufErr && !lockLost |=> rx_char_status == ST_REALIGN)
    else $error("realign status missing");
  chk_lock_entry: assert property (@(posedge ref_clk) disable iff (rst) // R2
    rxCharValid && rx_char_status == ST_LOCK && !$past(selfTest)
    |-> $past(state == SY_REALIGN) && state == SY_SYNCED)
    else $error("lock status without entering sync");
  chk_unbond_codes: assert property (@(posedge ref_clk) disable iff (rst) // R24
    charValid && !bonded && !selfTest |=> rx_char_status != ST_REALIGN
    && rx_char_status != ST_LOCK)
    else $error("unbonded mode reported realign or lock");
  chk_unbond_idle: assert property (@(posedge ref_clk) disable iff (rst) // R22
    !bonded |=> state == SY_UNSYNC)
    else $error("machine active without bonding");
  chk_four_framing: assert property (@(posedge ref_clk) disable iff (rst) // R13
    bonded && !typeB && state == SY_REALIGN && charValid && fourFraming && !ebufErr
    && !lockLost && !decErr |=> state == SY_SYNCED)
    else $error("four framing did not sync");
  chk_sync_drop: assert property (@(posedge ref_clk) disable iff (rst) // R15
    bonded && state == SY_SYNCED && charValid && fourErr |=> state == SY_UNSYNC)
    else $error("four errors did not drop sync");
  chk_st_notstart: assert property (@(posedge ref_clk) disable iff (rst) // R10
    charValid && selfTest && !stStarted |=> rx_char_status == ST_LOSS)
    else $error("self-test idle status wrong");
  chk_st_mismatch: assert property (@(posedge ref_clk) disable iff (rst) // R9
    charValid && selfTest && stStarted && !lockLost && !ebufErr && !stLastGood
    && !stLastBad && stMismatch |=> rx_char_status == ST_DISPERR)
    else $error("self-test mismatch not reported");

  cov_reach_sync:  cover property (@(posedge ref_clk) disable iff (rst)
    state == SY_REALIGN ##1 state == SY_SYNCED);
  cov_bond_fail:   cover property (@(posedge ref_clk) disable iff (rst)
    state == SY_BONDFAIL);
  cov_drop_sync:   cover property (@(posedge ref_clk) disable iff (rst)
    state == SY_SYNCED ##1 state == SY_UNSYNC);
  cov_st_lastbad:  cover property (@(posedge ref_clk) disable iff (rst)
    rxCharValid && selfTest && rx_char_status == ST_VIOL);
endmodule

/* core/rxss_pkg.sv */
// Purpose: Shared constants and types for the receive sync/status block
// Assumes: 100 MHz ref_clk, AXI4-Lite register access with 32-bit data
// Notes:   Status codes, substitute characters, register map, counter limits
package rxss_pkg;
  // Character status codes driven on rx_char_status
  localparam logic [2:0] ST_DATA     = 3'h0;
  localparam logic [2:0] ST_SPECIAL  = 3'h1;
  localparam logic [2:0] ST_LOCK     = 3'h2;
  localparam logic [2:0] ST_FRAMING  = 3'h3;
  localparam logic [2:0] ST_VIOL     = 3'h4;
  localparam logic [2:0] ST_LOSS     = 3'h5;
  localparam logic [2:0] ST_DISPERR  = 3'h6;
  localparam logic [2:0] ST_REALIGN  = 3'h7;
  // Substitute characters (x.y packed as y in [7:5], x in [4:0])
  localparam logic [7:0] CHAR_C0_7   = 8'he0;
  localparam logic [7:0] CHAR_C4_7   = 8'he4;
  // Counter limits
  localparam logic [2:0] CNT_FOUR    = 3'h4;
  localparam logic [2:0] CNT_THREE   = 3'h3;
  localparam logic [2:0] CNT_ZERO    = 3'h0;
  // Register map (byte addresses)
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_CHARCNT = 4'h8;
  // Control fields
  localparam int         CTRL_TYPEB  = 0;
  localparam int         CTRL_BOND   = 1;
  localparam int         CTRL_SELFT  = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h0;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Synchroniser state values
  typedef enum {SY_UNSYNC, SY_REALIGN, SY_BONDFAIL, SY_SYNCED} rxss_state_e;
endpackage

/* verification/rxss_host_model.sv */
// Purpose: Host side of the receive output bus, latching each presented character
// Assumes: rxCharValid is a one-cycle strobe that qualifies rxChar and rx_char_status
// Notes:   hostSeen pulses one cycle after each strobe, with the captured pair beside it
`timescale 1ns/1ps
module rxss_host_model
  import rxss_pkg::*;
(
  input  wire logic       ref_clk,        // 100 MHz clock
  input  wire logic       rst,            // Async reset, active high
  input  wire logic [7:0] rxChar,         // Character from the block
  input  wire logic [2:0] rx_char_status, // Status from the block
  input  wire logic       rxCharValid,    // Character strobe
  output logic      [7:0] hostChar,       // Captured character
  output logic      [2:0] hostStatus,     // Captured status
  output logic            hostSeen        // Capture strobe
);
  // Capture the bus only in the strobe cycle, as a real host register would
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostChar   <= 8'h00;
      hostStatus <= 3'h0;
      hostSeen   <= 1'b0;
    end else begin
      hostSeen <= rxCharValid;
      if (rxCharValid) begin
        hostChar   <= rxChar;
        hostStatus <= rx_char_status;
      end
    end
  end
endmodule

/* verification/tb_top.sv */
// Purpose: Self-checking bench for the receive sync and status block
// Assumes: AXI4-Lite master tasks, host model on the output bus
// Notes:   Expected results are queued by the driver and popped by the monitor
`timescale 1ns/1ps
module tb_top;
  import rxss_pkg::*;
  logic ref_clk = 0, rst = 1, charValid = 0, charFraming = 0, charSpecial = 0;
  logic charCodeErr = 0, charDispErr = 0, ebufErr = 0, pllLock = 1, bond_inhibit = 0;
  logic deskewExpired = 0, masterBondFail = 0, bondedToMaster = 0, stStarted = 0;
  logic stLastBad = 0, stLastGood = 0, stMismatch = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] rxChar, decodedChar = 0, hostChar;
  logic [2:0] rx_char_status, hostStatus;
  logic rxCharValid, hostSeen;
  logic [12:0] e, expQ[$];
  logic [15:0] s = 16'he826;
  int error_cnt = 0, samples_checked = 0;
  // Clock at 10 ns period
  always #5 ref_clk = ~ref_clk;
  rxss_sync_status dut_u (.*);
  rxss_host_model host_u (.*);
  // Shared compare
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Status by rank: code error, framing, disparity, special, data
  function automatic logic [2:0] exp_st(input logic [3:0] f);
    if (f[1]) return ST_VIOL;
    if (f[3]) return ST_FRAMING;
    if (f[0]) return ST_DISPERR;
    if (f[2]) return ST_SPECIAL;
    return ST_DATA;
  endfunction
  // Write: AW and W offered together, each released at its own handshake
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic pa, pw, ta, tw;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(negedge ref_clk);
      ta = pa && (s_axi_awready === 1'b1);
      tw = pw && (s_axi_wready === 1'b1);
      @(posedge ref_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask
  // One character; ck enables the status compare, cc the character compare
  task automatic send(input logic [3:0] f, input logic [7:0] c, input logic [2:0] st,
                      input logic ck, input logic cc);
    @(posedge ref_clk);
    charValid <= 1'b1;
    decodedChar <= c;
    {charFraming, charSpecial, charCodeErr, charDispErr} <= f;
    expQ.push_back({cc, ck, c, st});
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      charValid <= 1'b0;
    end
  endtask
  task automatic st_is(input logic [1:0] x);
    idle(3);
    rd(REG_STATUS, d, r);
    chk("state", d[3:2], x);
  endtask
  // Monitor: oldest note against each captured character
  always @(negedge ref_clk) begin
    if (hostSeen === 1'b1) begin
      if (expQ.size() == 0) chk("extra char", 1, 0);
      else begin
        e = expQ.pop_front();
        if (e[11]) chk("status", hostStatus, e[2:0]);
        if (e[12]) chk("char", hostChar, e[2:0] == ST_VIOL ? CHAR_C0_7 :
                       e[2:0] == ST_DISPERR ? CHAR_C4_7 : e[10:3]);
      end
    end
  end
  initial begin
    #300us;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    idle(3);
    rd(REG_CTRL, d, r);
    chk("ctrl reset", d, 0);
    rd(4'hc, d, r);
    chk("rdata", d, 32'h0);
    chk("rresp", r, RESP_SLVERR);
    wr(4'hc, 32'h7, r);
    chk("bresp", r, RESP_SLVERR);
    rd(REG_CTRL, d, r);
    chk("ctrl kept", d, 0);
    // Unbonded, both types: random characters and flags
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, m, r);
      for (int i = 0; i < 16; i++) begin
        s = lfsr(s);
        send(s[3:0], s[15:8], exp_st(s[3:0]), 1, 1);
      end
      idle(3);
    end
    // Bonded type A: sync up, then four decoder errors
    wr(REG_CTRL, 32'h2, r);
    idle(2);
    send(0, 8'h11, ST_LOSS, 1, 0);
    send(8, 8'hbc, 0, 0, 0);
    repeat (2) send(8, 8'hbc, ST_REALIGN, 1, 1);
    repeat (2) send(8, 8'hbc, 0, 0, 0);
    st_is(3);
    send(0, 8'h22, ST_DATA, 1, 1);
    repeat (3) send(2, 8'h33, ST_VIOL, 1, 1);
    send(2, 8'h33, 0, 0, 0);
    st_is(0);
    // Type A bond timeout, bond-failed, data entry, buffer error
    send(8, 8'hbc, 0, 0, 0);
    send(8, 8'hbc, ST_REALIGN, 1, 1);
    idle(1);
    deskewExpired <= 1'b1;
    send(0, 8'h40, ST_REALIGN, 1, 1);
    st_is(2);
    deskewExpired <= 1'b0;
    send(0, 8'h44, ST_LOSS, 1, 0);
    st_is(3);
    send(0, 8'h48, ST_LOSS, 1, 0);
    ebufErr <= 1'b1;
    idle(1);
    ebufErr <= 1'b0;
    st_is(0);
    // Type B paths
    wr(REG_CTRL, 32'h3, r);
    bondedToMaster <= 1'b1;
    repeat (2) send(8, 8'hbc, 0, 0, 0);
    st_is(3);
    {bondedToMaster, masterBondFail, bond_inhibit, deskewExpired} <= 4'h7;
    idle(4);
    send(0, 8'h55, 0, 0, 0);
    st_is(2);
    {masterBondFail, deskewExpired} <= 2'h0;
    send(2, 8'h66, 0, 0, 0);
    st_is(1);
    send(1, 8'h66, 0, 0, 0);
    st_is(0);
    send(8, 8'hbc, 0, 0, 0);
    idle(1);
    {masterBondFail, deskewExpired} <= 2'h3;
    send(0, 8'h77, ST_REALIGN, 1, 1);
    st_is(0);
    {masterBondFail, deskewExpired, bond_inhibit} <= 3'h0;
    // Self-test statuses
    wr(REG_CTRL, 32'h4, r);
    send(0, 8'h00, ST_LOSS, 1, 0);
    idle(1);
    {stStarted, stMismatch} <= 2'h3;
    send(0, 8'h01, ST_DISPERR, 1, 0);
    idle(1);
    {stMismatch, stLastBad} <= 2'h1;
    send(0, 8'h02, ST_VIOL, 1, 0);
    idle(1);
    {stLastBad, stLastGood} <= 2'h1;
    send(0, 8'h03, ST_LOCK, 1, 0);
    idle(1);
    {stLastGood, pllLock} <= 2'h0;
    idle(3);
    send(0, 8'h04, ST_LOSS, 1, 0);
    idle(1);
    pllLock <= 1'b1;
    idle(6);
    chk("notes left", expQ.size(), 0);
    close_out();
  end
endmodule
